// ===== logic/imas_consts.svh
`ifndef IMAS_CONSTS_SVH
`define IMAS_CONSTS_SVH

// Register file geometry and reset contents
`define IMAS_NUM_REGS 16
`define IMAS_REG_RST 32'h0000_0000

// Address space map, lower bounds inclusive, upper bounds inclusive
`define IMAS_LONG_LO 32'h0010_0000
`define IMAS_LONG_HI 32'h001f_ffff
`define IMAS_SHORT_LO 32'h0020_0000
`define IMAS_SHORT_HI 32'h003f_ffff
`define IMAS_BYTE_LO 32'h0100_0000

// Immediate width allowed in combined compute and address instructions
`define IMAS_IMM_MF_BITS 6

// Offset shift per unit size in byte space
`define IMAS_SHIFT_BYTE 2'h0
`define IMAS_SHIFT_SHORT 2'h1
`define IMAS_SHIFT_WORD 2'h2

`endif

// ===== logic/imas_pkg.sv
package imas_pkg;

    typedef enum logic [1:0] {
        IMAS_OP_ACCESS,
        IMAS_OP_MODIFY,
        IMAS_OP_BIT_REVERSE_MODIFY_OP
    } imas_op_e;

    typedef enum logic [1:0] {
        IMAS_ACC_NORMAL,
        IMAS_ACC_BYTE,
        IMAS_ACC_SHORT,
        IMAS_ACC_LONG
    } imas_acc_e;

    typedef enum logic [1:0] {
        IMAS_FLAG_NONE,
        IMAS_FLAG_SW,
        IMAS_FLAG_NW
    } imas_flag_e;

    typedef enum logic [1:0] {
        IMAS_SPACE_NORMAL,
        IMAS_SPACE_LONG,
        IMAS_SPACE_SHORT,
        IMAS_SPACE_BYTE
    } imas_space_e;

    typedef enum logic [1:0] {
        IMAS_FILE_INDEX,
        IMAS_FILE_MODIFY,
        IMAS_FILE_BASE,
        IMAS_FILE_LENGTH
    } imas_file_e;

endpackage

// ===== logic/imas_wrap.sv
`timescale 1ns/1ps

module imas_wrap (
    input wire logic [31:0] idx_i,
    input wire logic [31:0] base_i,
    input wire logic [31:0] len_i,
    input wire logic [31:0] mod_i,
    input wire logic scale_en_i,
    input wire logic [1:0] shift_amt_i,
    input wire logic shift_right_i,
    input wire logic circ_i,
    output logic [31:0] result_o
);
    logic [31:0] s_mod;
    logic [31:0] s_len;
    logic [31:0] sum;
    logic [31:0] top;

    // Scaling touches only the working copies, never the stored registers
    always_comb begin
        if (!scale_en_i) begin
            s_mod = mod_i;
            s_len = len_i;
        end else if (shift_right_i) begin
            s_mod = mod_i >> shift_amt_i;
            s_len = len_i >> shift_amt_i;
        end else begin
            s_mod = mod_i << shift_amt_i;
            s_len = len_i << shift_amt_i;
        end
    end

    // Unsigned 32-bit arithmetic, carries dropped
    assign sum = idx_i + s_mod;
    assign top = base_i + s_len;

    always_comb begin
        if (circ_i && (sum >= top)) begin
            result_o = sum - s_len;
        end else if (circ_i && (sum < base_i)) begin
            result_o = sum + s_len;
        end else begin
            result_o = sum;
        end
    end
endmodule // imas_wrap

// ===== logic/imas_top.sv
`timescale 1ns/1ps
`include "imas_consts.svh"
// Contract
// - Post-modify access presents index, then writes index plus modifier back.
// - Byte-space scaling never alters stored modifier or length registers.
// - Modify updates any of sixteen index registers with no memory access.
// - Modify takes a modifier register or an immediate up to 32 bits.
// - Modify wraps circularly whenever length is set, ignoring circular enable.
// - Enhanced modify writes destination and leaves a distinct source untouched.
// - Enhanced modify wraps with source base and length; destination gets wrapped value.
// - Immediates are 32 bits for single access, 6 bits in combined instructions.
// - Bit-reverse op adds immediate, reverses sum, writes back, ignoring reverse mode.
// - Enhanced bit-reverse writes the reversed value into a named destination.
// - Bit-reverse operation applies no byte-space scaling.
// - Scaling applies only to byte-space pointers, never to word-space pointers.
// - Accesses scale by size, normal and forced long by four; modifies scale by flag.
// - With scaling, circular length is scaled by the same unit size.
// - Byte or short access outside byte space interrupts; size is ignored.
// - Short flag outside byte space, or word flag in long/short space, interrupts.
// - Modify without size flag adds modifier unscaled in any space.
// - In byte space short flag adds twice, word flag four times modifier.
// - Reverse-mode pointers test space after reversal and shift offset down.
// - Short-flag modify shifts right when index 0/8 reverse mode set, else left.
// - Circular sum wraps down at base plus length, up below base.

module imas_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input wire imas_pkg::imas_op_e op_kind_i,
    input wire logic [3:0] src_idx_i,
    input wire logic [3:0] dst_idx_i,
    input wire logic [3:0] mod_sel_i,
    input wire logic use_imm_i,
    input wire logic [31:0] imm_i,
    input wire logic multifunc_i,
    input wire imas_pkg::imas_acc_e acc_size_i,
    input wire imas_pkg::imas_flag_e mod_flag_i,
    input wire logic circular_buffer_enable_i,
    input wire logic reverse_mode_index_zero_i,
    input wire logic reverse_mode_index_eight_i,
    input wire logic wr_en_i,
    input wire imas_pkg::imas_file_e wr_file_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire imas_pkg::imas_file_e rd_file_i,
    input wire logic [3:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    output logic [31:0] addr_o,
    output logic addr_valid_o,
    output logic illegal_space_interrupt_o
);
    logic [31:0] idx_q [`IMAS_NUM_REGS];
    logic [31:0] mod_q [`IMAS_NUM_REGS];
    logic [31:0] base_q [`IMAS_NUM_REGS];
    logic [31:0] len_q [`IMAS_NUM_REGS];
    logic [31:0] addr_q;
    logic addr_valid_q;
    logic illegal_space_interrupt_q;
    logic [31:0] rd_data_q;

    logic [31:0] src_val;
    logic [31:0] rev_src;
    logic [31:0] bsum;
    logic [31:0] brev_sum;
    logic [31:0] test_addr;
    logic [31:0] mod_raw;
    logic [31:0] wrap_val;
    logic [31:0] wb_val;
    logic [3:0] wb_idx;
    logic br_mode;
    logic circ;
    logic scale_en;
    logic [1:0] shift_amt;
    logic illegal;
    logic wb_en;
    logic is_access;
    logic is_modify;
    logic is_bit_reverse_modify_op;
    imas_pkg::imas_space_e space;

    assign is_access = (op_kind_i == imas_pkg::IMAS_OP_ACCESS);
    assign is_modify = (op_kind_i == imas_pkg::IMAS_OP_MODIFY);
    assign is_bit_reverse_modify_op = (op_kind_i == imas_pkg::IMAS_OP_BIT_REVERSE_MODIFY_OP);

    assign src_val = idx_q[src_idx_i];
    assign br_mode = ((src_idx_i == 4'h0) && reverse_mode_index_zero_i) ||
                     ((src_idx_i == 4'h8) && reverse_mode_index_eight_i);

    // Immediate narrowed and sign extended in combined instructions
    always_comb begin
        if (!use_imm_i) begin
            mod_raw = mod_q[mod_sel_i];
        end else if (multifunc_i) begin
            mod_raw = {{(32 - `IMAS_IMM_MF_BITS){imm_i[`IMAS_IMM_MF_BITS - 1]}},
                       imm_i[`IMAS_IMM_MF_BITS - 1:0]};
        end else begin
            mod_raw = imm_i;
        end
    end

    assign bsum = src_val + mod_raw;

    // Bit order reversal of the index and of the bit-reverse sum
    for (genvar b = 0; b < 32; b++) begin : g_rev
        assign rev_src[b] = src_val[31 - b];
        assign brev_sum[b] = bsum[31 - b];
    end

    // Space is judged on the address as it leaves, after any reversal
    assign test_addr = br_mode ? rev_src : src_val;

    always_comb begin
        if (test_addr >= `IMAS_BYTE_LO) begin
            space = imas_pkg::IMAS_SPACE_BYTE;
        end else if ((test_addr >= `IMAS_SHORT_LO) && (test_addr <= `IMAS_SHORT_HI)) begin
            space = imas_pkg::IMAS_SPACE_SHORT;
        end else if ((test_addr >= `IMAS_LONG_LO) && (test_addr <= `IMAS_LONG_HI)) begin
            space = imas_pkg::IMAS_SPACE_LONG;
        end else begin
            space = imas_pkg::IMAS_SPACE_NORMAL;
        end
    end

    // Scale selection and illegal space detection
    always_comb begin
        scale_en = 1'b0;
        shift_amt = `IMAS_SHIFT_BYTE;
        illegal = 1'b0;
        case (op_kind_i)
            imas_pkg::IMAS_OP_ACCESS: begin
                if ((acc_size_i == imas_pkg::IMAS_ACC_BYTE) ||
                    (acc_size_i == imas_pkg::IMAS_ACC_SHORT)) begin
                    illegal = (space != imas_pkg::IMAS_SPACE_BYTE);
                end
                scale_en = (space == imas_pkg::IMAS_SPACE_BYTE);
                case (acc_size_i)
                    imas_pkg::IMAS_ACC_BYTE: shift_amt = `IMAS_SHIFT_BYTE;
                    imas_pkg::IMAS_ACC_SHORT: shift_amt = `IMAS_SHIFT_SHORT;
                    default: shift_amt = `IMAS_SHIFT_WORD;
                endcase
            end
            imas_pkg::IMAS_OP_MODIFY: begin
                case (mod_flag_i)
                    imas_pkg::IMAS_FLAG_SW: begin
                        illegal = (space != imas_pkg::IMAS_SPACE_BYTE);
                        scale_en = (space == imas_pkg::IMAS_SPACE_BYTE);
                        shift_amt = `IMAS_SHIFT_SHORT;
                    end
                    imas_pkg::IMAS_FLAG_NW: begin
                        illegal = (space == imas_pkg::IMAS_SPACE_LONG) ||
                                  (space == imas_pkg::IMAS_SPACE_SHORT);
                        scale_en = (space == imas_pkg::IMAS_SPACE_BYTE);
                        shift_amt = `IMAS_SHIFT_WORD;
                    end
                    default: begin
                        scale_en = 1'b0;
                    end
                endcase
            end
            default: begin
                scale_en = 1'b0;
            end
        endcase
    end

    // Modify wraps whenever a length is set; accesses need the enable
    assign circ = (len_q[src_idx_i] != 32'h0000_0000) &&
                  (is_modify || (is_access && circular_buffer_enable_i));

    imas_wrap u_wrap (
        .idx_i(src_val),
        .base_i(base_q[src_idx_i]),
        .len_i(len_q[src_idx_i]),
        .mod_i(mod_raw),
        .scale_en_i(scale_en),
        .shift_amt_i(shift_amt),
        .shift_right_i(br_mode),
        .circ_i(circ),
        .result_o(wrap_val)
    );

    assign wb_val = is_bit_reverse_modify_op ? brev_sum : wrap_val;
    assign wb_idx = is_access ? src_idx_i : dst_idx_i;
    assign wb_en = op_valid_i && !(is_modify && illegal);

    // Index file: operation result wins over a software write to the same entry
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < `IMAS_NUM_REGS; k++) begin
                idx_q[k] <= `IMAS_REG_RST;
            end
        end else begin
            if (wr_en_i && (wr_file_i == imas_pkg::IMAS_FILE_INDEX)) begin
                idx_q[wr_idx_i] <= wr_data_i;
            end
            if (wb_en) begin
                idx_q[wb_idx] <= wb_val;
            end
        end
    end

    // Modifier, base and length change only by software write
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < `IMAS_NUM_REGS; k++) begin
                mod_q[k] <= `IMAS_REG_RST;
                base_q[k] <= `IMAS_REG_RST;
                len_q[k] <= `IMAS_REG_RST;
            end
        end else if (wr_en_i) begin
            case (wr_file_i)
                imas_pkg::IMAS_FILE_MODIFY: mod_q[wr_idx_i] <= wr_data_i;
                imas_pkg::IMAS_FILE_BASE: base_q[wr_idx_i] <= wr_data_i;
                imas_pkg::IMAS_FILE_LENGTH: len_q[wr_idx_i] <= wr_data_i;
                default: ;
            endcase
        end
    end

    // Presented address is the unmodified, possibly reversed, index
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            addr_q <= 32'h0000_0000;
            addr_valid_q <= 1'b0;
        end else begin
            addr_valid_q <= op_valid_i && is_access;
            if (op_valid_i && is_access) begin
                addr_q <= test_addr;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            illegal_space_interrupt_q <= 1'b0;
        end else begin
            illegal_space_interrupt_q <= op_valid_i && illegal;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_data_q <= 32'h0000_0000;
        end else begin
            case (rd_file_i)
                imas_pkg::IMAS_FILE_INDEX: rd_data_q <= idx_q[rd_idx_i];
                imas_pkg::IMAS_FILE_MODIFY: rd_data_q <= mod_q[rd_idx_i];
                imas_pkg::IMAS_FILE_BASE: rd_data_q <= base_q[rd_idx_i];
                default: rd_data_q <= len_q[rd_idx_i];
            endcase
        end
    end

    assign addr_o = addr_q;
    assign addr_valid_o = addr_valid_q;
    assign illegal_space_interrupt_o = illegal_space_interrupt_q;
    assign rd_data_o = rd_data_q;

    // Checks
    logic plain_mod;
    assign plain_mod = op_valid_i && is_modify && !br_mode &&
                       (len_q[src_idx_i] == 32'h0000_0000);

    post_addr_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_access && !br_mode |=> addr_valid_o && (addr_o == $past(src_val)))
        else $error("post-modify address is not the old index");

    post_wb_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_access && !circ && !scale_en |=>
        idx_q[$past(src_idx_i)] == $past(src_val + mod_raw))
        else $error("post-modify index not updated by modifier");

    no_access_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && !is_access |=> !addr_valid_o)
        else $error("modify started a memory access");

    mod_keep_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && !wr_en_i |=> (mod_q[$past(mod_sel_i)] == $past(mod_q[mod_sel_i])) &&
        (len_q[$past(src_idx_i)] == $past(len_q[src_idx_i])))
        else $error("scaling altered modifier or length");

    src_keep_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && !is_access && (dst_idx_i != src_idx_i) && !wr_en_i |=>
        idx_q[$past(src_idx_i)] == $past(src_val))
        else $error("enhanced op changed its source index");

    imm_short_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        use_imm_i && multifunc_i |-> mod_raw == {{26{imm_i[5]}}, imm_i[5:0]})
        else $error("combined-instruction immediate wider than six bits");

    no_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        plain_mod && (mod_flag_i == imas_pkg::IMAS_FLAG_NONE) |=>
        idx_q[$past(dst_idx_i)] == $past(src_val + mod_raw))
        else $error("unflagged modify scaled its modifier");

    nw_scale_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        plain_mod && (mod_flag_i == imas_pkg::IMAS_FLAG_NW) &&
        (space == imas_pkg::IMAS_SPACE_BYTE) |=>
        idx_q[$past(dst_idx_i)] == $past(src_val + {mod_raw[29:0], 2'b00}))
        else $error("word-flagged modify did not add four times");

    sw_illegal_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_modify && (mod_flag_i == imas_pkg::IMAS_FLAG_SW) &&
        (space != imas_pkg::IMAS_SPACE_BYTE) |=> illegal_space_interrupt_o)
        else $error("short-flag modify outside byte space not flagged");

    acc_illegal_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_access && (acc_size_i == imas_pkg::IMAS_ACC_BYTE) &&
        (space == imas_pkg::IMAS_SPACE_NORMAL) |=> illegal_space_interrupt_o ##1
        !illegal_space_interrupt_o || $past(op_valid_i && illegal))
        else $error("byte access outside byte space not flagged");

    bit_reverse_modify_op_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_bit_reverse_modify_op |=> idx_q[$past(dst_idx_i)][31] == $past(bsum[0]) &&
        idx_q[$past(dst_idx_i)][0] == $past(bsum[31]))
        else $error("bit-reverse result not reversed");

    wrap_down_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_modify && !circular_buffer_enable_i &&
        (mod_flag_i == imas_pkg::IMAS_FLAG_NONE) && (len_q[src_idx_i] != 32'h0000_0000) &&
        (bsum >= base_q[src_idx_i] + len_q[src_idx_i]) |=>
        idx_q[$past(dst_idx_i)] == $past(bsum - len_q[src_idx_i]))
        else $error("modify did not wrap down with circular enable off");

    wrap_up_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_modify && (mod_flag_i == imas_pkg::IMAS_FLAG_NONE) &&
        (len_q[src_idx_i] != 32'h0000_0000) && (bsum < base_q[src_idx_i]) &&
        (bsum < base_q[src_idx_i] + len_q[src_idx_i]) |=>
        idx_q[$past(dst_idx_i)] == $past(bsum + len_q[src_idx_i]))
        else $error("modify below base did not wrap up");

    sw_fwd_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        plain_mod && (mod_flag_i == imas_pkg::IMAS_FLAG_SW) &&
        (space == imas_pkg::IMAS_SPACE_BYTE) |=>
        idx_q[$past(dst_idx_i)] == $past(src_val + {mod_raw[30:0], 1'b0}))
        else $error("short-flagged modify did not add twice");

    sw_rev_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_modify && br_mode && (mod_flag_i == imas_pkg::IMAS_FLAG_SW) &&
        (space == imas_pkg::IMAS_SPACE_BYTE) && (len_q[src_idx_i] == 32'h0000_0000) |=>
        idx_q[$past(dst_idx_i)] == $past(src_val + {1'b0, mod_raw[31:1]}))
        else $error("reverse-mode short modify did not shift down");

    nw_illegal_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        op_valid_i && is_modify && (mod_flag_i == imas_pkg::IMAS_FLAG_NW) && !wr_en_i &&
        ((space == imas_pkg::IMAS_SPACE_LONG) || (space == imas_pkg::IMAS_SPACE_SHORT)) |=>
        illegal_space_interrupt_o && (idx_q[$past(dst_idx_i)] == $past(idx_q[dst_idx_i])))
        else $error("word-flagged modify in word space not refused");

    wrap_cov_c: cover property (@(posedge clock_i) op_valid_i && is_modify && circ &&
        (wrap_val != bsum));
    illegal_space_interrupt_cov_c: cover property (@(posedge clock_i) illegal_space_interrupt_o);
    brev_cov_c: cover property (@(posedge clock_i) op_valid_i && is_bit_reverse_modify_op &&
        (dst_idx_i != src_idx_i));
    scale_cov_c: cover property (@(posedge clock_i) op_valid_i && scale_en && br_mode);
    acc_byte_c: cover property (@(posedge clock_i) op_valid_i && is_access && scale_en);
endmodule // imas_top

// ===== testbench/imas_decoder_model.sv
`timescale 1ns/1ps
// Decoder side: changes requests after the falling edge, holds them over one rising edge
module imas_decoder_model (
    input wire logic clock_i,
    output logic op_valid_o,
    output imas_pkg::imas_op_e op_kind_o,
    output logic [3:0] src_idx_o,
    output logic [3:0] dst_idx_o,
    output logic [3:0] mod_sel_o,
    output logic use_imm_o,
    output logic [31:0] imm_o,
    output logic multifunc_o,
    output imas_pkg::imas_acc_e acc_size_o,
    output imas_pkg::imas_flag_e mod_flag_o,
    output logic cbuf_en_o,
    output logic rev0_o,
    output logic rev8_o,
    output logic wr_en_o,
    output imas_pkg::imas_file_e wr_file_o,
    output logic [3:0] wr_idx_o,
    output logic [31:0] wr_data_o,
    output imas_pkg::imas_file_e rd_file_o,
    output logic [3:0] rd_idx_o
);
    initial begin
        op_valid_o = 1'b0;
        wr_en_o = 1'b0;
        op(2'h0, 4'h0, 4'h0, 4'h0, 1'b0, 32'h0, 1'b0, 2'h0, 2'h0, 3'h0, 1'b0);
        wr_file_o = imas_pkg::IMAS_FILE_INDEX;
        wr_idx_o = 4'h0;
        wr_data_o = 32'h0;
        rd_file_o = imas_pkg::IMAS_FILE_INDEX;
        rd_idx_o = 4'h0;
    end

    task automatic op(input logic [1:0] k, input logic [3:0] s, d, m, input logic ui,
                      input logic [31:0] iv, input logic mf, input logic [1:0] az, fl,
                      input logic [2:0] modes, input logic go);
        if (go) @(negedge clock_i);
        op_valid_o = go;
        op_kind_o = imas_pkg::imas_op_e'(k);
        src_idx_o = s;
        dst_idx_o = d;
        mod_sel_o = m;
        use_imm_o = ui;
        imm_o = iv;
        multifunc_o = mf;
        acc_size_o = imas_pkg::imas_acc_e'(az);
        mod_flag_o = imas_pkg::imas_flag_e'(fl);
        {cbuf_en_o, rev0_o, rev8_o} = modes;
        if (go) @(negedge clock_i);
        op_valid_o = 1'b0;
    endtask

    task automatic wr(input logic [1:0] f, input logic [3:0] i, input logic [31:0] v);
        @(negedge clock_i);
        wr_en_o = 1'b1;
        wr_file_o = imas_pkg::imas_file_e'(f);
        wr_idx_o = i;
        wr_data_o = v;
        @(negedge clock_i);
        wr_en_o = 1'b0;
    endtask

    task automatic rd(input logic [1:0] f, input logic [3:0] i);
        @(negedge clock_i);
        rd_file_o = imas_pkg::imas_file_e'(f);
        rd_idx_o = i;
        @(negedge clock_i);
    endtask
endmodule // imas_decoder_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "imas_consts.svh"
module tb_top;
    logic clock_i, sys_rst_i, op_valid_i, use_imm_i, multifunc_i, wr_en_i;
    logic circular_buffer_enable_i, reverse_mode_index_zero_i, reverse_mode_index_eight_i;
    imas_pkg::imas_op_e op_kind_i;
    imas_pkg::imas_acc_e acc_size_i;
    imas_pkg::imas_flag_e mod_flag_i;
    imas_pkg::imas_file_e wr_file_i, rd_file_i;
    logic [3:0] src_idx_i, dst_idx_i, mod_sel_i, wr_idx_i, rd_idx_i;
    logic [31:0] imm_i, wr_data_i, rd_data_o, addr_o;
    logic addr_valid_o, illegal_space_interrupt_o;
    logic [31:0] rf[4][16];
    logic [31:0] tab[4] = '{`IMAS_LONG_LO + 32'h40, `IMAS_SHORT_LO + 32'h40,
                            `IMAS_BYTE_LO + 32'h40, 32'h1};
    logic [31:0] r, iv;
    logic [3:0] s, d, msel;
    logic [1:0] k, az, fl;
    logic ui, mf, ce, b0, b8;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'h6a9b;

    imas_top uut (.clock_i, .sys_rst_i, .op_valid_i, .op_kind_i, .src_idx_i, .dst_idx_i,
        .mod_sel_i, .use_imm_i, .imm_i, .multifunc_i, .acc_size_i, .mod_flag_i,
        .circular_buffer_enable_i, .reverse_mode_index_zero_i, .reverse_mode_index_eight_i,
        .wr_en_i, .wr_file_i, .wr_idx_i, .wr_data_i, .rd_file_i, .rd_idx_i, .rd_data_o,
        .addr_o, .addr_valid_o, .illegal_space_interrupt_o);

    imas_decoder_model dec (.clock_i, .op_valid_o(op_valid_i), .op_kind_o(op_kind_i),
        .src_idx_o(src_idx_i), .dst_idx_o(dst_idx_i), .mod_sel_o(mod_sel_i),
        .use_imm_o(use_imm_i), .imm_o(imm_i), .multifunc_o(multifunc_i),
        .acc_size_o(acc_size_i), .mod_flag_o(mod_flag_i), .cbuf_en_o(circular_buffer_enable_i),
        .rev0_o(reverse_mode_index_zero_i), .rev8_o(reverse_mode_index_eight_i),
        .wr_en_o(wr_en_i), .wr_file_o(wr_file_i), .wr_idx_o(wr_idx_i), .wr_data_o(wr_data_i),
        .rd_file_o(rd_file_i), .rd_idx_o(rd_idx_i));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rev(input logic [31:0] v);
        for (int j = 0; j < 32; j++) rev[j] = v[31-j];
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdchk(input logic [1:0] f, input logic [3:0] i, input logic [31:0] e);
        dec.rd(f, i);
        chk("rd_data", e, rd_data_o);
    endtask

    task automatic wreg(input logic [1:0] f, input logic [3:0] i, input logic [31:0] v);
        dec.wr(f, i, v);
        rf[f][i] = v;
    endtask

    // Works out the expected answer, issues the operation, then checks ports and registers
    task automatic go();
        logic [31:0] md, p, sm, sl, sum, e;
        logic rv, byt, wsp, bad;
        int sh;
        rv = (s == 4'h0 && b0) || (s == 4'h8 && b8);
        p = rv ? rev(rf[0][s]) : rf[0][s];
        byt = p >= `IMAS_BYTE_LO;
        wsp = p >= `IMAS_LONG_LO && p <= `IMAS_SHORT_HI;
        md = !ui ? rf[1][msel] : mf ? {{26{iv[5]}}, iv[5:0]} : iv;
        sh = 0;
        bad = 1'b0;
        if (k == 2'h0) begin
            bad = (az == 2'h1 || az == 2'h2) && !byt;
            sh = !byt ? 0 : az == 2'h1 ? 0 : az == 2'h2 ? 1 : 2;
        end else if (k == 2'h1) begin
            bad = (fl == 2'h1 && !byt) || (fl == 2'h2 && wsp);
            sh = byt ? int'(fl) : 0;
        end
        sm = rv ? md >> sh : md << sh;
        sl = rv ? rf[3][s] >> sh : rf[3][s] << sh;
        sum = rf[0][s] + sm;
        e = sum;
        if (rf[3][s] != 32'h0 && (k == 2'h1 || (k == 2'h0 && ce))) begin
            if (sum >= rf[2][s] + sl) e = sum - sl;
            else if (sum < rf[2][s]) e = sum + sl;
        end
        if (k == 2'h2) e = rev(sum);
        dec.op(k, s, d, msel, ui, iv, mf, az, fl, {ce, b0, b8}, 1'b1);
        chk("illegal", {31'h0, bad}, {31'h0, illegal_space_interrupt_o});
        chk("addr_valid", {31'h0, k == 2'h0}, {31'h0, addr_valid_o});
        if (k == 2'h0) chk("addr", p, addr_o);
        if (!(bad && k == 2'h1)) rf[0][k == 2'h0 ? s : d] = e;
        rdchk(2'h0, d, rf[0][d]);
        rdchk(2'h0, s, rf[0][s]);
        rdchk(2'h1, msel, rf[1][msel]);
        rdchk(2'h3, s, rf[3][s]);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        sys_rst_i = 1'b1;
        foreach (rf[f, i]) rf[f][i] = `IMAS_REG_RST;
        repeat (16) @(negedge clock_i);
        sys_rst_i = 1'b0;
        for (int f = 0; f < 4; f++) rdchk(2'(f), 4'h5, `IMAS_REG_RST);
        chk("idle_valid", 32'h0, {31'h0, addr_valid_o});
        // Wrap example: destination gets the wrapped value, source stays
        wreg(2'h2, 4'h0, 32'h0004_0000);
        wreg(2'h3, 4'h0, 32'h0001_0000);
        wreg(2'h0, 4'h0, 32'h0004_ffff);
        {k, s, d, msel, ui, iv, mf, az, fl, ce, b0, b8} =
            {2'h1, 4'h0, 4'h1, 4'h0, 1'b1, 32'h2, 5'h00, 3'h0};
        go();
        rdchk(2'h0, 4'h1, 32'h0004_0001);
        // Sizes and flags against long, short and byte space, reverse mode on index zero
        for (int t = 0; t < 32; t++) begin
            k = t[4] ? 2'h1 : 2'h0;
            az = t[1:0];
            fl = t[1:0] == 2'h3 ? 2'h0 : t[1:0];
            {s, d, msel, ui, mf, ce, b8} = {4'h0, 4'h0, 4'h2, 4'h2};
            b0 = t[3:2] == 2'h3;
            wreg(2'h0, 4'h0, tab[t[3:2]]);
            wreg(2'h2, 4'h0, tab[t[3:2]]);
            wreg(2'h3, 4'h0, t[2] ? 32'h0 : 32'h10);
            wreg(2'h1, 4'h2, 32'h6);
            go();
        end
        for (int n = 0; n < 200; n++) begin
            r = $random(seed);
            iv = $random(seed);
            k = r[1:0] == 2'h3 ? 2'h1 : r[1:0];
            s = r[5:2];
            d = r[6] ? s : r[10:7];
            msel = r[14:11];
            {ui, mf, az, ce, b0, b8} = r[21:15];
            fl = r[24:23] == 2'h3 ? 2'h1 : r[24:23];
            wreg(2'h1, msel, {{24{r[25]}}, r[31:24]});
            wreg(2'h2, s, tab[r[27:26]] + (iv & 32'hfff));
            wreg(2'h3, s, r[28] ? (iv >> 20) & 32'hff : 32'h0);
            wreg(2'h0, s, rf[2][s] + (iv & 32'h1ff));
            go();
        end
        print_verdict();
    end
endmodule // tb_top
